// file: address_stepper.v
// Address counter step with display and glyph memory wrap
`timescale 1ns/100ps
`include "char_display_map.vh"
module address_stepper (
  input wire [6:0] i_address,
  input wire i_glyph,
  input wire i_up,
  output reg [6:0] o_next
);
  always @* begin
    if (i_glyph) begin
      o_next = {1'b0, i_up ? i_address[5:0] + 6'h01 :
                i_address[5:0] - 6'h01};
    end else if (i_up) begin
      if (i_address == `LINE1_LAST) begin
        o_next = `LINE2_FIRST;
      end else if (i_address == `LINE2_LAST) begin
        o_next = `HOME_ADDR;
      end else begin
        o_next = i_address + 7'h01;
      end
    end else begin
      if (i_address == `LINE2_FIRST) begin
        o_next = `LINE1_LAST;
      end else if (i_address == `HOME_ADDR) begin
        o_next = `LINE2_LAST;
      end else begin
        o_next = i_address - 7'h01;
      end
    end
  end
endmodule // address_stepper

// file: char_display_instruction_decoder.v
// Instruction decoder, memories and scan lookup of a 2x20 display
`timescale 1ns/100ps
`include "char_display_map.vh"
// Summary of operation
// - 64-byte glyph memory holds eight 5x8 glyphs
// - Codes 0-0F map to glyph rows, bit3 ignored
// - Clear fills spaces, homes, unshifts, sets increment
// - Home resets counter and shift, memories kept
// - Entry mode stores direction and shift enable
// - Display write shifts image when enabled
// - Display control latches display enable
// - Cursor lights eighth row at counter position
// - Blink alternates cursor character with all-lit
// - Shift command steps counter by direction bit
// - Shift-select bit moves image left or right
// - Shift command reselects display memory
// - Data transfers use counter and selected memory
// - Glyph address command loads six bits
// - Display address command loads seven bits
// - Command read returns counter, busy zero
// - Data write steps counter; display writes shift when enabled
module char_display_instruction_decoder #(
  parameter [25:0] BLINK_HALF_CYCLES = `BLINK_HALF_CYCLES
) (
  input wire i_clock,
  input wire i_rst,
  input wire i_strobe,
  input wire i_command_data_select,
  input wire i_read,
  input wire [7:0] i_data,
  input wire [4:0] i_scan_column,
  input wire i_scan_line,
  input wire [2:0] i_scan_row,
  output reg [7:0] o_read_data,
  output reg o_read_valid,
  output reg [6:0] o_address_counter,
  output reg o_glyph_select,
  output reg o_increment,
  output reg o_shift_enable,
  output reg o_display_on,
  output reg o_cursor_on,
  output reg o_blink_on,
  output reg [5:0] o_shift_offset,
  output reg [7:0] o_char_code,
  output reg [4:0] o_pixel_row,
  output reg o_pixel_override
);
  reg [7:0] display_memory [0:`DISPLAY_DEPTH-1];
  reg [`DISPLAY_DEPTH-1:0] display_written;
  reg [7:0] glyph_memory [0:`GLYPH_DEPTH-1];
  reg [25:0] blink_count;
  reg blink_phase;

  wire cmd_write = i_strobe & ~i_command_data_select & ~i_read;
  wire cmd_read = i_strobe & ~i_command_data_select & i_read;
  wire data_write = i_strobe & i_command_data_select & ~i_read;
  wire data_read = i_strobe & i_command_data_select & i_read;
  wire shift_cmd = cmd_write && i_data[7:5] == 3'h0 &&
    i_data[`CMD_SHIFT];
  wire step_up = shift_cmd ? i_data[2] : o_increment;
  wire [6:0] stepped;
  wire [7:0] display_value = display_written[o_address_counter] ?
    display_memory[o_address_counter] : `SPACE_CODE;
  wire [5:0] offset_left = (o_shift_offset == `SHIFT_LAST) ? 6'h00 :
    o_shift_offset + 6'h01;
  wire [5:0] offset_right = (o_shift_offset == 6'h00) ? `SHIFT_LAST :
    o_shift_offset - 6'h01;

  address_stepper u_stepper (
    .i_address(o_address_counter),
    .i_glyph(o_glyph_select & ~shift_cmd),
    .i_up(step_up),
    .o_next(stepped)
  );

  // Scan lookup of the character at a screen position
  wire [5:0] column_sum = {1'b0, i_scan_column} + o_shift_offset;
  wire [5:0] column_addr = (column_sum >= `COLUMN_WRAP) ?
    column_sum - `COLUMN_WRAP : column_sum;
  wire [6:0] scan_addr = {i_scan_line, column_addr};
  wire [7:0] scan_code = display_written[scan_addr] ?
    display_memory[scan_addr] : `SPACE_CODE;
  wire [5:0] scan_glyph_addr = {scan_code[2:0], i_scan_row};
  wire scan_user = scan_code[7:4] == 4'h0;
  wire at_cursor = ~o_glyph_select && scan_addr == o_address_counter;
  // Blink wins over the underline cursor
  wire blink_lit = at_cursor && o_blink_on && blink_phase;
  wire cursor_lit = at_cursor && o_cursor_on &&
    i_scan_row == `CURSOR_ROW;

  // One cycle behind the scan inputs
  always @(posedge i_clock) begin
    if (i_rst) begin
      o_char_code <= `SPACE_CODE;
      o_pixel_row <= 5'h00;
      o_pixel_override <= 1'b1;
    end else begin
      o_char_code <= scan_code;
      if (!o_display_on) begin
        o_pixel_row <= 5'h00;
        o_pixel_override <= 1'b1;
      end else if (blink_lit) begin
        o_pixel_row <= `ALL_LIT;
        o_pixel_override <= 1'b1;
      end else if (cursor_lit) begin
        o_pixel_row <= `ALL_LIT;
        o_pixel_override <= 1'b1;
      end else begin
        o_pixel_row <= glyph_memory[scan_glyph_addr][4:0];
        o_pixel_override <= scan_user;
      end
    end
  end

  // Divider tick once every half blink period
  wire blink_tick = blink_count == BLINK_HALF_CYCLES - 26'h0000001;
  always @(posedge i_clock) begin
    if (i_rst || !o_blink_on || blink_tick) begin
      blink_count <= 26'h0000000;
    end else begin
      blink_count <= blink_count + 26'h0000001;
    end
  end

  // Blink phase flips on each tick
  always @(posedge i_clock) begin
    if (i_rst || !o_blink_on) begin
      blink_phase <= 1'b0;
    end else if (blink_tick) begin
      blink_phase <= ~blink_phase;
    end
  end

  // No reset here: glyph memory keeps its patterns
  wire store_glyph = data_write & o_glyph_select & ~i_rst;
  wire store_display = data_write & ~o_glyph_select & ~i_rst;
  always @(posedge i_clock) begin
    if (store_glyph) begin
      glyph_memory[o_address_counter[5:0]] <= i_data;
    end
    if (store_display) begin
      display_memory[o_address_counter] <= i_data;
    end
  end

  // Command decode and machine state
  always @(posedge i_clock) begin
    if (i_rst) begin
      display_written <= {`DISPLAY_DEPTH{1'b0}};
      o_address_counter <= `HOME_ADDR;
      o_glyph_select <= 1'b0;
      o_increment <= `RST_INCREMENT;
      o_shift_enable <= `RST_SHIFT_ENABLE;
      o_display_on <= `RST_DISPLAY_ON;
      o_cursor_on <= `RST_CURSOR_ON;
      o_blink_on <= `RST_BLINK_ON;
      o_shift_offset <= 6'h00;
      o_read_data <= 8'h00;
      o_read_valid <= 1'b0;
    end else begin
      o_read_valid <= 1'b0;
      // Highest set bit picks the command
      if (cmd_write) begin
        if (i_data[`CMD_DISPLAY_ADDR]) begin
          o_address_counter <= i_data[6:0];
          o_glyph_select <= 1'b0;
        end else if (i_data[`CMD_GLYPH_ADDR]) begin
          o_address_counter <= {1'b0, i_data[5:0]};
          o_glyph_select <= 1'b1;
        end else if (i_data[`CMD_FUNCTION]) begin
          // Bus width, lines, brightness: nothing kept here
          o_glyph_select <= o_glyph_select;
        end else if (i_data[`CMD_SHIFT]) begin
          o_address_counter <= stepped;
          o_glyph_select <= 1'b0;
          if (i_data[3]) begin
            o_shift_offset <= i_data[2] ? offset_right :
              offset_left;
          end
        end else if (i_data[`CMD_CONTROL]) begin
          o_display_on <= i_data[2];
          o_cursor_on <= i_data[1];
          o_blink_on <= i_data[0];
        end else if (i_data[`CMD_ENTRY]) begin
          o_increment <= i_data[1];
          o_shift_enable <= i_data[0];
        end else if (i_data[`CMD_HOME]) begin
          o_address_counter <= `HOME_ADDR;
          o_glyph_select <= 1'b0;
          o_shift_offset <= 6'h00;
        end else if (i_data[`CMD_CLEAR]) begin
          // Written flags make clear a one-cycle job
          display_written <= {`DISPLAY_DEPTH{1'b0}};
          o_address_counter <= `HOME_ADDR;
          o_glyph_select <= 1'b0;
          o_shift_offset <= 6'h00;
          o_increment <= 1'b1;
        end
      end
      if (cmd_read) begin
        o_read_data <= {1'b0, o_address_counter};
        o_read_valid <= 1'b1;
      end
      if (data_write) begin
        if (!o_glyph_select) begin
          display_written[o_address_counter] <= 1'b1;
          if (o_shift_enable) begin
            o_shift_offset <= o_increment ? offset_left :
              offset_right;
          end
        end
        o_address_counter <= stepped;
      end
      // Reads step the counter but never shift
      if (data_read) begin
        o_read_data <= o_glyph_select ?
          glyph_memory[o_address_counter[5:0]] : display_value;
        o_read_valid <= 1'b1;
        o_address_counter <= stepped;
      end
    end
  end
endmodule // char_display_instruction_decoder

// file: char_display_instruction_decoder_sva.sv
// Port assertions for the instruction decoder
`timescale 1ns/100ps
module char_display_instruction_decoder_sva (
  input wire i_clock,
  input wire i_rst,
  input wire i_strobe,
  input wire i_command_data_select,
  input wire i_read,
  input wire [7:0] i_data,
  input wire [7:0] o_read_data,
  input wire o_read_valid,
  input wire [6:0] o_address_counter,
  input wire o_glyph_select,
  input wire o_increment,
  input wire o_shift_enable,
  input wire o_display_on,
  input wire [5:0] o_shift_offset
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_rst);
  sequence s_cmd;
    i_strobe && !i_command_data_select && !i_read;
  endsequence
  a_clear_all: assert property (s_cmd ##0 i_data == 8'h01 |=>
    o_address_counter == 7'h00 && o_increment && o_shift_offset == 6'h00)
    else $error("clear state wrong");
  a_home_reset: assert property (s_cmd ##0 i_data[7:1] == 7'h01 |=>
    o_address_counter == 7'h00 && o_shift_offset == 6'h00)
    else $error("home state wrong");
  a_entry_store: assert property (s_cmd ##0 i_data[7:2] == 6'h01 |=>
    o_increment == $past(i_data[1]) && o_shift_enable == $past(i_data[0]))
    else $error("entry flags wrong");
  a_display_latch: assert property (s_cmd ##0 i_data[7:3] == 5'h01 |=>
    o_display_on == $past(i_data[2])) else $error("display flag wrong");
  a_shift_reselect: assert property (s_cmd ##0 i_data[7:4] == 4'h1 |=>
    !o_glyph_select) else $error("glyph still selected");
  a_glyph_load: assert property (s_cmd ##0 i_data[7:6] == 2'h1 |=>
    o_glyph_select && o_address_counter == {1'b0, $past(i_data[5:0])})
    else $error("glyph address wrong");
  a_display_load: assert property (s_cmd ##0 i_data[7] |=>
    !o_glyph_select && o_address_counter == $past(i_data[6:0]))
    else $error("display address wrong");
  sequence s_cmd_read;
    i_strobe && !i_command_data_select && i_read;
  endsequence
  sequence s_data_read;
    i_strobe && i_command_data_select && i_read;
  endsequence
  a_counter_read: assert property (s_cmd_read |=> o_read_valid &&
    o_read_data == {1'b0, $past(o_address_counter)})
    else $error("counter read wrong");
  a_entry_keep: assert property (s_cmd ##0 i_data[7:2] == 6'h01 |=>
    $stable(o_address_counter)) else $error("entry moved counter");
  a_read_noshift: assert property (s_data_read |=>
    $stable(o_shift_offset)) else $error("read shifted display");
  a_read_pulse: assert property (!(i_strobe && i_read) |=>
    !o_read_valid) else $error("read valid without read");
endmodule // char_display_instruction_decoder_sva
bind char_display_instruction_decoder char_display_instruction_decoder_sva
  u_sva (.i_clock, .i_rst, .i_strobe, .i_command_data_select, .i_read,
  .i_data, .o_read_data, .o_read_valid, .o_address_counter, .o_glyph_select,
  .o_increment, .o_shift_enable, .o_display_on, .o_shift_offset);

// file: char_display_instruction_decoder_tb_top.sv
// Testbench for the instruction decoder
`timescale 1ns/100ps
module char_display_instruction_decoder_tb_top;
  reg i_clock = 1'b0;
  reg i_rst = 1'b1;
  reg [4:0] col = 5'h00;
  reg line = 1'b0;
  reg [2:0] prow = 3'h0;
  wire stb, sel, rd, rv, gs, inc, sen, don, con, bon, ovr;
  wire [7:0] dat, rdat, code;
  wire [6:0] ac;
  wire [5:0] ofs;
  wire [4:0] pix;
  integer error_cnt = 0;
  integer check_count = 0;
  integer i;
  reg [25:0] rows [0:15];
  host_model u_host_model (.i_clock(i_clock), .o_strobe(stb),
    .o_select(sel), .o_read(rd), .o_data(dat));
  char_display_instruction_decoder #(.BLINK_HALF_CYCLES(26'h8))
    u_char_display_instruction_decoder (.i_clock(i_clock), .i_rst(i_rst),
    .i_strobe(stb), .i_command_data_select(sel), .i_read(rd), .i_data(dat),
    .i_scan_column(col), .i_scan_line(line), .i_scan_row(prow),
    .o_read_data(rdat), .o_read_valid(rv), .o_address_counter(ac),
    .o_glyph_select(gs), .o_increment(inc), .o_shift_enable(sen),
    .o_display_on(don), .o_cursor_on(con), .o_blink_on(bon),
    .o_shift_offset(ofs), .o_char_code(code), .o_pixel_row(pix),
    .o_pixel_override(ovr));
  initial begin
    forever #5 i_clock = ~i_clock;
  end
  task chk(input [63:0] name, input [7:0] exp, input [7:0] got);
    check_count = check_count + 1;
    if (got !== exp) begin
      error_cnt = error_cnt + 1;
      $display("[ERR] %0s exp %h got %h", name, exp, got);
    end
  endtask
  task stop_test;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task x(input reg s, input reg r, input reg [7:0] d);
    u_host_model.xfer(s, r, d);
  endtask
  initial begin
    #400000;
    error_cnt = error_cnt + 1;
    stop_test;
  end
  initial begin
    // Rows: select, read, byte, counter after, glyph select, read data
    rows[0] = {2'h0, 8'h85, 7'h05, 1'b0, 8'h00};
    rows[1] = {2'h2, 8'h41, 7'h06, 1'b0, 8'h00};
    rows[2] = {2'h0, 8'h04, 7'h06, 1'b0, 8'h00};
    rows[3] = {2'h2, 8'h42, 7'h05, 1'b0, 8'h00};
    rows[4] = {2'h0, 8'h10, 7'h04, 1'b0, 8'h00};
    rows[5] = {2'h0, 8'h14, 7'h05, 1'b0, 8'h00};
    rows[6] = {2'h0, 8'h47, 7'h07, 1'b1, 8'h00};
    rows[7] = {2'h0, 8'h14, 7'h08, 1'b0, 8'h00};
    rows[8] = {2'h0, 8'h03, 7'h00, 1'b0, 8'h00};
    rows[9] = {2'h1, 8'h00, 7'h00, 1'b0, 8'h00};
    rows[10] = {2'h0, 8'h85, 7'h05, 1'b0, 8'h00};
    rows[11] = {2'h3, 8'h00, 7'h04, 1'b0, 8'h41};
    rows[12] = {2'h0, 8'h01, 7'h00, 1'b0, 8'h00};
    rows[13] = {2'h0, 8'h86, 7'h06, 1'b0, 8'h00};
    rows[14] = {2'h3, 8'h00, 7'h07, 1'b0, 8'h20};
    rows[15] = {2'h0, 8'h3F, 7'h07, 1'b0, 8'h00};
    repeat (16) @(negedge i_clock);
    i_rst = 1'b0;
    chk("counter", 8'h00, {1'b0, ac});
    chk("incr", 8'h01, {7'h00, inc});
    for (i = 0; i < 16; i = i + 1) begin
      x(rows[i][25], rows[i][24], rows[i][23:16]);
      chk("counter", {1'b0, rows[i][15:9]}, {1'b0, ac});
      chk("glyph", {7'h00, rows[i][8]}, {7'h00, gs});
      if (rows[i][24]) begin
        chk("rdata", rows[i][7:0], rdat);
        chk("rvalid", 8'h01, {7'h00, rv});
      end else begin
        chk("rvalid", 8'h00, {7'h00, rv});
      end
    end
    x(1'b0, 1'b0, 8'h07);
    chk("incr", 8'h01, {7'h00, inc});
    chk("shift_en", 8'h01, {7'h00, sen});
    x(1'b1, 1'b0, 8'h41);
    chk("offset", 8'h01, {2'h0, ofs});
    x(1'b0, 1'b0, 8'h18);
    chk("offset", 8'h02, {2'h0, ofs});
    x(1'b0, 1'b0, 8'h1C);
    chk("offset", 8'h01, {2'h0, ofs});
    x(1'b0, 1'b0, 8'h05);
    chk("incr", 8'h00, {7'h00, inc});
    x(1'b1, 1'b0, 8'h41);
    chk("offset", 8'h00, {2'h0, ofs});
    x(1'b0, 1'b0, 8'h06);
    chk("shift_en", 8'h00, {7'h00, sen});
    x(1'b0, 1'b0, 8'h0C);
    chk("disp", 8'h01, {7'h00, don});
    chk("curs_on", 8'h00, {7'h00, con});
    x(1'b0, 1'b0, 8'h40);
    x(1'b1, 1'b0, 8'h1F);
    x(1'b0, 1'b0, 8'h80);
    x(1'b1, 1'b0, 8'h08);
    x(1'b0, 1'b0, 8'h18);
    chk("offset", 8'h01, {2'h0, ofs});
    x(1'b0, 1'b0, 8'h02);
    chk("offset", 8'h00, {2'h0, ofs});
    chk("counter", 8'h00, {1'b0, ac});
    repeat (2) @(negedge i_clock);
    chk("code", 8'h08, code);
    chk("pixel", 8'h1F, {3'h0, pix});
    x(1'b0, 1'b0, 8'h0E);
    chk("curs_on", 8'h01, {7'h00, con});
    prow = 3'h7;
    repeat (2) @(negedge i_clock);
    chk("cursor", 8'h1F, {3'h0, pix});
    x(1'b0, 1'b0, 8'h08);
    repeat (2) @(negedge i_clock);
    chk("blank", 8'h20, {2'h0, ovr, pix});
    // Blink: glyph row 1 alternates with all-lit, 8-cycle halves
    x(1'b0, 1'b0, 8'h41);
    x(1'b1, 1'b0, 8'h0A);
    x(1'b0, 1'b0, 8'h80);
    prow = 3'h1;
    x(1'b0, 1'b0, 8'h0D);
    chk("blink_on", 8'h01, {7'h00, bon});
    repeat (4) @(negedge i_clock);
    chk("blink", 8'h0A, {3'h0, pix});
    repeat (8) @(negedge i_clock);
    chk("blink", 8'h1F, {3'h0, pix});
    repeat (8) @(negedge i_clock);
    chk("blink", 8'h0A, {3'h0, pix});
    // Reset in mid-run
    x(1'b0, 1'b0, 8'h05);
    i_rst = 1'b1;
    repeat (2) @(negedge i_clock);
    i_rst = 1'b0;
    chk("incr", 8'h01, {7'h00, inc});
    chk("shift_en", 8'h00, {7'h00, sen});
    chk("disp", 8'h00, {7'h00, don});
    chk("blink_on", 8'h00, {7'h00, bon});
    chk("code", 8'h20, code);
    chk("blank", 8'h20, {2'h0, ovr, pix});
    x(1'b0, 1'b1, 8'h00);
    chk("rdata", 8'h00, rdat);
    stop_test;
  end
endmodule // char_display_instruction_decoder_tb_top

// file: char_display_map.vh
// Constants for the character display instruction decoder
`ifndef CHAR_DISPLAY_MAP_VH
`define CHAR_DISPLAY_MAP_VH
`define DISPLAY_DEPTH 128
`define GLYPH_DEPTH 64
`define SPACE_CODE 8'h20
`define HOME_ADDR 7'h00
`define LINE1_LAST 7'h27
`define LINE2_FIRST 7'h40
`define LINE2_LAST 7'h67
`define GLYPH_LAST 6'h3F
`define SHIFT_LAST 6'h27
`define COLUMN_WRAP 6'h28
`define CURSOR_ROW 3'h7
`define ALL_LIT 5'h1F
`define CMD_DISPLAY_ADDR 7
`define CMD_GLYPH_ADDR 6
`define CMD_FUNCTION 5
`define CMD_SHIFT 4
`define CMD_CONTROL 3
`define CMD_ENTRY 2
`define CMD_HOME 1
`define CMD_CLEAR 0
`define RST_INCREMENT 1'b1
`define RST_SHIFT_ENABLE 1'b0
`define RST_DISPLAY_ON 1'b0
`define RST_CURSOR_ON 1'b0
`define RST_BLINK_ON 1'b0
`define BLINK_HALF_MS 500
`define CLOCK_KHZ 100000
// Half blink period in cycles: 500 ms at 100 MHz
`define BLINK_HALF_CYCLES 26'h2FAF080
`endif

// file: host_model.sv
// Host processor transfer model
`timescale 1ns/100ps
module host_model (
  input wire i_clock,
  output reg o_strobe,
  output reg o_select,
  output reg o_read,
  output reg [7:0] o_data
);
  initial begin
    o_strobe = 1'b0;
    o_select = 1'b0;
    o_read = 1'b0;
    o_data = 8'h00;
  end
  task xfer(input reg s, input reg r, input reg [7:0] d);
    @(negedge i_clock);
    o_strobe = 1'b1;
    o_select = s;
    o_read = r;
    o_data = d;
    @(negedge i_clock);
    o_strobe = 1'b0;
    o_data = ~d;
  endtask
endmodule // host_model
